// *** sdram_addr_map_init_bcast.sv ***
// SDRAM controller slice: address mapping, init commands, refresh and write broadcast
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 12x10 geometry maps internal bits onto memory address bits per fixed table.
// - 12x11 geometry uses its own upper-bit table, lower bits as 12x10.
// - 13x8 geometry uses its own upper-bit table with common lower bits.
// - 13-row geometries with 9,10,11 columns use their own upper-bit tables.
// - Column phase drives memory bit 15 high with auto-precharge, else low.
// - Memory bit 19 selects bank for two banks; bits 19,18 for four.
// - Command register write issues precharge-all or mode-register-set to memory.
// - One timing setting applies to every channel.
// - Refresh counter counts down once per refresh issued, stopping at zero.
// - Refresh requests win over every other memory request.
// - Disabled channel is idle; enabled channel without master/slave is normal.
// - Write to a master channel also writes every enabled slave channel.
// - Slave-only channel acts normally and gets only master broadcast writes.
// - Master-and-slave channel broadcasts its writes and accepts others' broadcasts.
// - Broadcast writes use the master channel's check mode for all channels.
module sdram_addr_map_init_bcast #(
   parameter int NUM_CHAN = 4,
   parameter int CW = $clog2(NUM_CHAN)
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic acc_valid_i,
   output logic acc_ready_o,
   input wire logic acc_write_i,
   input wire logic [CW-1:0] acc_chan_i,
   input wire logic [31:0] acc_addr_i,
   input wire logic acc_ap_i,
   output sdram_map_pkg::mem_cmd_type mem_cmd_o,
   output logic [14:0] mem_addr_o,
   output logic [NUM_CHAN-1:0] mem_chan_o,
   output logic [2:0] check_mode_o
);
   typedef struct packed {
      sdram_map_pkg::phase_type st;
      logic [NUM_CHAN-1:0][10:0] chan;
      logic [15:0] period;
      logic [15:0] timer;
      logic rf_pend;
      logic [11:0] rcount;
      logic cmd_pend;
      logic [1:0] cmd_code;
      logic [14:0] mode_val;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] a_addr;
      logic a_write;
      logic a_ap;
      logic [2:0] a_geo;
      logic [NUM_CHAN-1:0] a_sel;
      sdram_map_pkg::mem_cmd_type cmd;
      logic [14:0] maddr;
      logic [NUM_CHAN-1:0] msel;
      logic [2:0] chk;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic [NUM_CHAN-1:0] on_mask;
   logic [NUM_CHAN-1:0] tgt_mask;
   logic [2:0] mux_geo;
   logic [31:0] mux_addr;
   logic mux_col;
   logic mux_ap;
   logic [14:0] mapped;

   // Byte-lane merge of a register write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Register decode: channel index or 0..NUM_CHAN-1, NUM_CHAN timing, +1 cmd, +2 unmapped
   function automatic int decode(input logic [7:0] a);
      int k;
      k = NUM_CHAN + 2;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (a == 8'(sdram_map_pkg::CHAN_BASE + 4 * i)) begin
            k = i;
         end
      end
      if (a == sdram_map_pkg::TIMING_OFF) begin
         k = NUM_CHAN;
      end
      if (a == sdram_map_pkg::CMD_OFF) begin
         k = NUM_CHAN + 1;
      end
      return k;
   endfunction : decode

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_mask
      assign on_mask[g] = s_q.chan[g][sdram_map_pkg::CH_ON_BIT];
      assign tgt_mask[g] = s_q.chan[g][sdram_map_pkg::CH_ON_BIT] &
                           s_q.chan[g][sdram_map_pkg::TGT_BIT];
   end

   assign mux_col = (s_q.st == sdram_map_pkg::ST_COL);
   assign mux_geo = mux_col ? s_q.a_geo : s_q.chan[acc_chan_i][sdram_map_pkg::GEO_LSB +: 3];
   assign mux_addr = mux_col ? s_q.a_addr : acc_addr_i;
   assign mux_ap = s_q.a_ap;

   sdram_addr_mux u_mux (
      .geo_i(mux_geo),
      .addr_i(mux_addr),
      .col_phase_i(mux_col),
      .ap_i(mux_ap),
      .maddr_o(mapped)
   );

   assign acc_ready_o = (s_q.st == sdram_map_pkg::ST_IDLE) && !s_q.rf_pend
                        && !s_q.cmd_pend;
   assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign mem_cmd_o = s_q.cmd;
   assign mem_addr_o = s_q.maddr;
   assign mem_chan_o = s_q.msel;
   assign check_mode_o = s_q.chk;

   always_comb begin
      int k;
      logic [31:0] wv;
      logic [10:0] cr;
      s_d = s_q;
      k = 0;
      wv = 32'h0000_0000;
      cr = s_q.chan[acc_chan_i];
      s_d.cmd = sdram_map_pkg::MC_NOP;
      s_d.msel = '0;
      // Refresh timer; a zero period stops refresh generation
      if (s_q.period != 16'h0000 && s_q.timer >= s_q.period - 16'h0001) begin
         s_d.timer = 16'h0000;
      end else begin
         s_d.timer = s_q.timer + 16'h0001;
      end
      // Memory command sequencing
      case (s_q.st)
         sdram_map_pkg::ST_IDLE: begin
            if (s_q.rf_pend) begin
               s_d.cmd = sdram_map_pkg::MC_REFRESH;
               s_d.msel = on_mask;
               s_d.rf_pend = 1'b0;
               if (s_q.rcount != 12'h000) begin
                  s_d.rcount = s_q.rcount - 12'h001;
               end
            end else if (s_q.cmd_pend) begin
               s_d.cmd = (s_q.cmd_code == sdram_map_pkg::CMD_PALL) ?
                         sdram_map_pkg::MC_PALL : sdram_map_pkg::MC_MRS;
               s_d.maddr = s_q.mode_val;
               s_d.msel = on_mask;
               s_d.cmd_pend = 1'b0;
            end else if (acc_valid_i) begin
               s_d.a_addr = acc_addr_i;
               s_d.a_write = acc_write_i;
               s_d.a_ap = acc_ap_i;
               s_d.a_geo = mux_geo;
               s_d.chk = cr[sdram_map_pkg::CHK_LSB +: 3];
               if (!cr[sdram_map_pkg::CH_ON_BIT]) begin
                  s_d.a_sel = '0;
               end else if (acc_write_i && cr[sdram_map_pkg::SRC_BIT]) begin
                  s_d.a_sel = tgt_mask;
                  s_d.a_sel[acc_chan_i] = 1'b1;
               end else begin
                  s_d.a_sel = '0;
                  s_d.a_sel[acc_chan_i] = 1'b1;
               end
               s_d.cmd = sdram_map_pkg::MC_ACT;
               s_d.maddr = mapped;
               s_d.msel = s_d.a_sel;
               s_d.st = sdram_map_pkg::ST_COL;
            end
         end
         sdram_map_pkg::ST_COL: begin
            s_d.cmd = s_q.a_write ? sdram_map_pkg::MC_WR : sdram_map_pkg::MC_RD;
            s_d.maddr = mapped;
            s_d.msel = s_q.a_sel;
            s_d.st = sdram_map_pkg::ST_IDLE;
         end
         default: begin
            s_d.st = sdram_map_pkg::ST_IDLE;
         end
      endcase
      // Expiry sets after the issue clears, so a coincident tick is kept
      if (s_q.period != 16'h0000 && s_q.timer >= s_q.period - 16'h0001) begin
         s_d.rf_pend = 1'b1;
      end
      // AXI write channel
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.aw_got && s_q.w_got) begin
         k = decode(s_q.aw_addr);
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = sdram_map_pkg::RESP_OKAY;
         if (k < NUM_CHAN) begin
            wv = merge({21'h000000, s_q.chan[k]}, s_q.wdata, s_q.wstrb);
            s_d.chan[k] = wv[10:0];
         end else if (k == NUM_CHAN) begin
            wv = merge({4'h0, s_q.rcount, s_q.period}, s_q.wdata, s_q.wstrb);
            s_d.period = wv[sdram_map_pkg::RP_LSB +: 16];
            s_d.rcount = wv[sdram_map_pkg::RC_LSB +: 12];
         end else if (k == NUM_CHAN + 1) begin
            wv = merge({14'h0000, s_q.cmd_code, 1'b0, s_q.mode_val}, s_q.wdata, s_q.wstrb);
            s_d.mode_val = wv[14:0];
            s_d.cmd_code = wv[sdram_map_pkg::CMD_LSB +: 2];
            if (wv[sdram_map_pkg::CMD_LSB +: 2] == sdram_map_pkg::CMD_PALL ||
                wv[sdram_map_pkg::CMD_LSB +: 2] == sdram_map_pkg::CMD_MRS) begin
               s_d.cmd_pend = 1'b1;
            end
         end else begin
            s_d.bresp = sdram_map_pkg::RESP_SLVERR;
         end
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // AXI read channel
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         k = decode(s_axi_araddr);
         s_d.rvalid = 1'b1;
         s_d.rresp = sdram_map_pkg::RESP_OKAY;
         if (k < NUM_CHAN) begin
            s_d.rdata = {21'h000000, s_q.chan[k]};
         end else if (k == NUM_CHAN) begin
            s_d.rdata = {4'h0, s_q.rcount, s_q.period};
         end else if (k == NUM_CHAN + 1) begin
            s_d.rdata = {14'h0000, s_q.cmd_code, s_q.cmd_pend, s_q.mode_val};
         end else begin
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = sdram_map_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         s_q <= '0;
         s_q.st <= sdram_map_pkg::ST_IDLE;
         s_q.cmd <= sdram_map_pkg::MC_NOP;
         s_q.period <= sdram_map_pkg::RP_RESET;
         for (int i = 0; i < NUM_CHAN; i++) begin
            s_q.chan[i] <= sdram_map_pkg::CHAN_RESET;
         end
      end else begin
         s_q <= s_d;
      end
   end

   a_refresh_first: assert property (@(posedge clock_i) disable iff (srst_i)
      s_q.st == sdram_map_pkg::ST_IDLE && s_q.rf_pend
      |=> mem_cmd_o == sdram_map_pkg::MC_REFRESH && mem_chan_o == $past(on_mask))
      else $error("refresh not issued first");

   a_count_down: assert property (@(posedge clock_i) disable iff (srst_i)
      mem_cmd_o == sdram_map_pkg::MC_REFRESH && $past(s_q.rcount) != 12'h000
      && !$past(s_q.aw_got && s_q.w_got)
      |-> s_q.rcount == $past(s_q.rcount) - 12'h001)
      else $error("refresh counter did not step down");

   a_ap_column: assert property (@(posedge clock_i) disable iff (srst_i)
      (mem_cmd_o == sdram_map_pkg::MC_WR || mem_cmd_o == sdram_map_pkg::MC_RD)
      |-> mem_addr_o[10] == s_q.a_ap && mem_addr_o[7:0] == s_q.a_addr[9:2])
      else $error("column phase auto-precharge or low bits wrong");

   a_bank_stable: assert property (@(posedge clock_i) disable iff (srst_i)
      mem_cmd_o == sdram_map_pkg::MC_ACT
      |=> mem_addr_o[14:13] == $past(mem_addr_o[14:13]) && mem_chan_o == $past(mem_chan_o))
      else $error("bank bits changed between row and column");

   a_no_disabled: assert property (@(posedge clock_i) disable iff (srst_i)
      (mem_cmd_o == sdram_map_pkg::MC_ACT) |-> (mem_chan_o & ~$past(on_mask)) == '0)
      else $error("disabled channel selected");

   a_broadcast_all: assert property (@(posedge clock_i) disable iff (srst_i)
      s_q.st == sdram_map_pkg::ST_IDLE && acc_valid_i && acc_ready_o && acc_write_i
      && s_q.chan[acc_chan_i][sdram_map_pkg::CH_ON_BIT]
      && s_q.chan[acc_chan_i][sdram_map_pkg::SRC_BIT]
      ##1 1'b1 |=> (mem_chan_o & $past(tgt_mask, 2)) == $past(tgt_mask, 2))
      else $error("broadcast target missed");

   a_init_issue: assert property (@(posedge clock_i) disable iff (srst_i)
      s_q.cmd_pend && !s_q.rf_pend && s_q.st == sdram_map_pkg::ST_IDLE
      |=> mem_cmd_o == sdram_map_pkg::MC_PALL || mem_cmd_o == sdram_map_pkg::MC_MRS)
      else $error("init command not issued");

   a_check_mode: assert property (@(posedge clock_i) disable iff (srst_i)
      mem_cmd_o == sdram_map_pkg::MC_ACT
      |-> check_mode_o == $past(s_q.chan[acc_chan_i][sdram_map_pkg::CHK_LSB +: 3]))
      else $error("check mode not taken from requesting channel");

   c_refresh: cover property (@(posedge clock_i) mem_cmd_o == sdram_map_pkg::MC_REFRESH);
   c_broadcast: cover property (@(posedge clock_i)
      mem_cmd_o == sdram_map_pkg::MC_WR && $countones(mem_chan_o) > 1);
   c_mode_set: cover property (@(posedge clock_i) mem_cmd_o == sdram_map_pkg::MC_MRS);
endmodule : sdram_addr_map_init_bcast
`default_nettype wire

// *** sdram_addr_mux.sv ***
// Internal-to-memory address multiplexer for row and column phases
`timescale 1ns/1ps
`default_nettype none
module sdram_addr_mux (
   input wire logic [2:0] geo_i,
   input wire logic [31:0] addr_i,
   input wire logic col_phase_i,
   input wire logic ap_i,
   output logic [14:0] maddr_o
);
   // Source bit numbers for memory bits 19,18,17,16,14,13 (column) and 19..16 (row)
   logic [5:0][4:0] col_src;
   logic [3:0][4:0] row_src;

   always_comb begin
      case (geo_i)
         sdram_map_pkg::GEO_12X11: begin
            col_src = {5'd25, 5'd26, 5'd25, 5'd24, 5'd23, 5'd22};
            row_src = {5'd25, 5'd26, 5'd25, 5'd21};
         end
         sdram_map_pkg::GEO_13X8: begin
            col_src = {5'd23, 5'd24, 5'd22, 5'd21, 5'd24, 5'd23};
            row_src = {5'd23, 5'd24, 5'd22, 5'd21};
         end
         sdram_map_pkg::GEO_13X9: begin
            col_src = {5'd24, 5'd25, 5'd22, 5'd21, 5'd24, 5'd23};
            row_src = {5'd24, 5'd25, 5'd22, 5'd21};
         end
         sdram_map_pkg::GEO_13X10: begin
            col_src = {5'd25, 5'd26, 5'd22, 5'd21, 5'd24, 5'd23};
            row_src = {5'd25, 5'd26, 5'd22, 5'd21};
         end
         sdram_map_pkg::GEO_13X11: begin
            col_src = {5'd26, 5'd27, 5'd22, 5'd25, 5'd24, 5'd23};
            row_src = {5'd26, 5'd27, 5'd22, 5'd21};
         end
         default: begin
            col_src = {5'd24, 5'd25, 5'd24, 5'd21, 5'd23, 5'd22};
            row_src = {5'd24, 5'd25, 5'd24, 5'd21};
         end
      endcase
   end

   always_comb begin
      if (col_phase_i) begin
         maddr_o[14:11] = {addr_i[col_src[5]], addr_i[col_src[4]],
                           addr_i[col_src[3]], addr_i[col_src[2]]};
         maddr_o[10] = ap_i;
         maddr_o[9:8] = {addr_i[col_src[1]], addr_i[col_src[0]]};
         maddr_o[7:0] = addr_i[9:2];
      end else begin
         maddr_o[14:11] = {addr_i[row_src[3]], addr_i[row_src[2]],
                           addr_i[row_src[1]], addr_i[row_src[0]]};
         maddr_o[10:0] = addr_i[20:10];
      end
   end
endmodule : sdram_addr_mux
`default_nettype wire

// *** sdram_map_pkg.sv ***
// Shared constants and types for the SDRAM address map, init and broadcast block
package sdram_map_pkg;
   localparam logic [7:0] CHAN_BASE = 8'h00;
   localparam logic [7:0] TIMING_OFF = 8'h10;
   localparam logic [7:0] CMD_OFF = 8'h14;
   localparam int CH_ON_BIT = 0;
   localparam int SRC_BIT = 1;
   localparam int TGT_BIT = 2;
   localparam int GEO_LSB = 4;
   localparam int CHK_LSB = 8;
   localparam int RP_LSB = 0;
   localparam int RC_LSB = 16;
   localparam int CMD_LSB = 16;
   localparam logic [10:0] CHAN_RESET = 11'h000;
   localparam logic [15:0] RP_RESET = 16'h0100;
   localparam logic [1:0] CMD_PALL = 2'h1;
   localparam logic [1:0] CMD_MRS = 2'h2;
   localparam logic [2:0] GEO_12X10 = 3'h0;
   localparam logic [2:0] GEO_12X11 = 3'h1;
   localparam logic [2:0] GEO_13X8 = 3'h2;
   localparam logic [2:0] GEO_13X9 = 3'h3;
   localparam logic [2:0] GEO_13X10 = 3'h4;
   localparam logic [2:0] GEO_13X11 = 3'h5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      MC_NOP = 3'b000,
      MC_REFRESH = 3'b001,
      MC_PALL = 3'b010,
      MC_MRS = 3'b011,
      MC_ACT = 3'b100,
      MC_WR = 3'b101,
      MC_RD = 3'b110
   } mem_cmd_type;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_COL = 1'b1
   } phase_type;
endpackage : sdram_map_pkg

// *** sdram_mem_model.sv ***
// Behavioural memory at the far side: records every command it receives except NOP
`timescale 1ns/1ps
`default_nettype none
module sdram_mem_model #(
   parameter int NCH = 4
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire sdram_map_pkg::mem_cmd_type cmd_i,
   input wire logic [14:0] addr_i,
   input wire logic [NCH-1:0] chan_i,
   input wire logic [2:0] check_i
);
   int ref_n = 0;
   int init_n = 0;
   int data_n = 0;
   logic [14:0] row_q, col_q, init_q;
   logic [NCH-1:0] chan_q, ref_chan_q;
   logic [2:0] chk_q, init_cmd_q;
   logic wr_q;
   always @(posedge clock_i) begin
      if (!srst_i) begin
         case (cmd_i)
            sdram_map_pkg::MC_REFRESH: begin
               ref_n <= ref_n + 1;
               ref_chan_q <= chan_i;
            end
            sdram_map_pkg::MC_PALL, sdram_map_pkg::MC_MRS: begin
               init_n <= init_n + 1;
               init_q <= addr_i;
               init_cmd_q <= cmd_i;
            end
            sdram_map_pkg::MC_ACT: begin
               row_q <= addr_i;
               chan_q <= chan_i;
               chk_q <= check_i;
            end
            sdram_map_pkg::MC_WR, sdram_map_pkg::MC_RD: begin
               col_q <= addr_i;
               wr_q <= (cmd_i == sdram_map_pkg::MC_WR);
               data_n <= data_n + 1;
            end
            default: begin
            end
         endcase
      end
   end
endmodule : sdram_mem_model
`default_nettype wire

// *** tb_sdram_addr_map_init_bcast.sv ***
// Self-checking bench: registers, init commands, refresh, address map, broadcast
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_addr_map_init_bcast;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, acc_addr = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, acc_ready;
   logic [1:0] bresp, rresp, acc_chan = 2'h0;
   logic acc_valid = 1'b0, acc_write = 1'b0, acc_ap = 1'b0;
   logic [3:0] wstrb = 4'hF;
   sdram_map_pkg::mem_cmd_type mem_cmd;
   logic [14:0] mem_addr;
   logic [3:0] mem_chan;
   logic [2:0] check_mode;
   int err_total = 0;
   int total_checks = 0;
   always #2.5 clock_i = ~clock_i;
   sdram_addr_map_init_bcast #(.NUM_CHAN(4)) DUT (.clock_i(clock_i), .srst_i(srst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .acc_valid_i(acc_valid), .acc_ready_o(acc_ready), .acc_write_i(acc_write),
      .acc_chan_i(acc_chan), .acc_addr_i(acc_addr), .acc_ap_i(acc_ap), .mem_cmd_o(mem_cmd),
      .mem_addr_o(mem_addr), .mem_chan_o(mem_chan), .check_mode_o(check_mode));
   sdram_mem_model #(.NCH(4)) mem (.clock_i(clock_i), .srst_i(srst_i), .cmd_i(mem_cmd),
      .addr_i(mem_addr), .chan_i(mem_chan), .check_i(check_mode));
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic hang(input string what);
      err_total++;
      $display("unexpected at %0t: timeout in %s", $time, what);
      close_out();
   endtask : hang
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic aw_hit, w_hit, b_hit;
      int n;
      @(posedge clock_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_hit = 1'b0;
      n = 0;
      while (!b_hit) begin
         @(negedge clock_i);
         aw_hit = awvalid && awready === 1'b1;
         w_hit = wvalid && wready === 1'b1;
         b_hit = bvalid === 1'b1;
         resp = bresp;
         @(posedge clock_i);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         n++;
         if (n > 50) hang("write");
      end
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic ar_hit, r_hit;
      int n;
      @(posedge clock_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_hit = 1'b0;
      n = 0;
      while (!r_hit) begin
         @(negedge clock_i);
         ar_hit = arvalid && arready === 1'b1;
         r_hit = rvalid === 1'b1;
         d = rdata;
         resp = rresp;
         @(posedge clock_i);
         if (ar_hit) arvalid <= 1'b0;
         n++;
         if (n > 50) hang("read");
      end
      rready <= 1'b0;
   endtask : axi_rd
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk({30'h0, r}, {30'h0, sdram_map_pkg::RESP_OKAY}, "write resp");
   endtask : reg_wr
   task automatic access(input logic [1:0] ch, input logic wr, input logic [31:0] a,
                         input logic ap);
      logic hit;
      int n0, n;
      n0 = mem.data_n;
      @(posedge clock_i);
      acc_chan <= ch;
      acc_write <= wr;
      acc_addr <= a;
      acc_ap <= ap;
      acc_valid <= 1'b1;
      hit = 1'b0;
      n = 0;
      while (!hit) begin
         @(negedge clock_i);
         hit = acc_ready === 1'b1;
         @(posedge clock_i);
         n++;
         if (n > 600) hang("access");
      end
      acc_valid <= 1'b0;
      n = 0;
      while (mem.data_n == n0) begin
         @(negedge clock_i);
         n++;
         if (n > 20) hang("column");
      end
   endtask : access
   task automatic wait_init(input int target);
      int n;
      n = 0;
      while (mem.init_n != target) begin
         @(negedge clock_i);
         n++;
         if (n > 40) hang("init command");
      end
   endtask : wait_init
   // Per geometry: row bits 19..16, column bits 17,16,14,13 (column 19,18 match row)
   function automatic logic [14:0] map_exp(input int g, input logic [31:0] a, input logic col,
                                           input logic ap);
      int t[8];
      logic [14:0] m;
      case (g)
         1: t = '{25, 26, 25, 21, 25, 24, 23, 22};
         2: t = '{23, 24, 22, 21, 22, 21, 24, 23};
         3: t = '{24, 25, 22, 21, 22, 21, 24, 23};
         4: t = '{25, 26, 22, 21, 22, 21, 24, 23};
         5: t = '{26, 27, 22, 21, 22, 25, 24, 23};
         default: t = '{24, 25, 24, 21, 24, 21, 23, 22};
      endcase
      m[14] = a[t[0]];
      m[13] = a[t[1]];
      m[12] = col ? a[t[4]] : a[t[2]];
      m[11] = col ? a[t[5]] : a[t[3]];
      m[10] = col ? ap : a[20];
      m[9] = col ? a[t[6]] : a[19];
      m[8] = col ? a[t[7]] : a[18];
      m[7:0] = col ? a[9:2] : a[17:10];
      return m;
   endfunction : map_exp
   task automatic t_reset_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(sdram_map_pkg::CHAN_BASE, d, r);
      chk(d, 32'h0, "channel reset");
      axi_rd(sdram_map_pkg::TIMING_OFF, d, r);
      chk(d, {16'h0, sdram_map_pkg::RP_RESET}, "timing reset");
      axi_rd(8'h40, d, r);
      chk({30'h0, r}, {30'h0, sdram_map_pkg::RESP_SLVERR}, "unmapped read");
      axi_wr(8'h44, 32'hFFFF_FFFF, r);
      chk({30'h0, r}, {30'h0, sdram_map_pkg::RESP_SLVERR}, "unmapped write");
      // Only byte lane 1 enabled: just the check mode field may change
      wstrb <= 4'h2;
      axi_wr(sdram_map_pkg::CHAN_BASE + 8'h0C, 32'hFFFF_FFFF, r);
      wstrb <= 4'hF;
      axi_rd(sdram_map_pkg::CHAN_BASE + 8'h0C, d, r);
      chk(d, 32'h0000_0700, "byte lane write");
   endtask : t_reset_regs
   task automatic t_init();
      int n0;
      reg_wr(sdram_map_pkg::CHAN_BASE, 32'h1);
      reg_wr(sdram_map_pkg::CHAN_BASE + 8'h04, 32'h1);
      reg_wr(sdram_map_pkg::TIMING_OFF, 32'h0);
      n0 = mem.init_n;
      reg_wr(sdram_map_pkg::CMD_OFF, {14'h0, sdram_map_pkg::CMD_PALL, 1'b0, 15'h0400});
      wait_init(n0 + 1);
      chk(mem.init_cmd_q, sdram_map_pkg::MC_PALL, "precharge-all");
      chk(mem.init_q, 32'h0400, "precharge-all addr");
      reg_wr(sdram_map_pkg::CMD_OFF, {14'h0, sdram_map_pkg::CMD_MRS, 1'b0, 15'h0032});
      wait_init(n0 + 2);
      chk(mem.init_cmd_q, sdram_map_pkg::MC_MRS, "mode set");
      chk(mem.init_q, 32'h0032, "mode set addr");
   endtask : t_init
   task automatic t_refresh();
      logic [31:0] d;
      logic [1:0] r;
      int n0, dn, n;
      n0 = mem.ref_n;
      reg_wr(sdram_map_pkg::TIMING_OFF, {4'h0, 12'd3, 16'd8});
      d = 32'hFFFF_FFFF;
      n = 0;
      while (d[27:16] !== 12'h0) begin
         axi_rd(sdram_map_pkg::TIMING_OFF, d, r);
         n++;
         if (n > 40) hang("countdown");
      end
      dn = mem.ref_n - n0;
      chk({31'h0, dn >= 3 && dn <= 4}, 32'h1, "refresh count");
      chk(mem.ref_chan_q, 32'h3, "refresh channels");
      n = 0;
      while (mem.ref_n == n0 + dn) begin
         @(negedge clock_i);
         n++;
         if (n > 40) hang("refresh");
      end
      axi_rd(sdram_map_pkg::TIMING_OFF, d, r);
      chk(d[27:16], 32'h0, "countdown holds at zero");
      reg_wr(sdram_map_pkg::TIMING_OFF, 32'h0000_0100);
   endtask : t_refresh
   task automatic t_map();
      logic [31:0] a;
      for (int k = 0; k < 2; k++) begin
         a = (k == 0) ? 32'h0A5C_3B96 : 32'h05A3_C469;
         for (int g = 0; g < 6; g++) begin
            reg_wr(sdram_map_pkg::CHAN_BASE, 32'h1 | (g << sdram_map_pkg::GEO_LSB));
            access(2'h0, k[0], a, g[0] ^ k[0]);
            chk(mem.row_q, map_exp(g, a, 1'b0, 1'b0), "row addr");
            chk(mem.col_q, map_exp(g, a, 1'b1, g[0] ^ k[0]), "col addr");
         end
      end
   endtask : t_map
   task automatic t_bcast();
      logic [1:0] ch[5] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h3};
      logic wr[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      logic [3:0] sel[5] = '{4'h7, 4'h6, 4'h2, 4'h1, 4'h0};
      logic [2:0] cm[5] = '{3'h5, 3'h2, 3'h0, 3'h5, 3'h0};
      // All channels keep the same geometry so a broadcast lands alike
      reg_wr(sdram_map_pkg::CHAN_BASE, 32'h0000_0503);
      reg_wr(sdram_map_pkg::CHAN_BASE + 8'h04, 32'h0000_0005);
      reg_wr(sdram_map_pkg::CHAN_BASE + 8'h08, 32'h0000_0207);
      reg_wr(sdram_map_pkg::CHAN_BASE + 8'h0C, 32'h0000_0004);
      for (int i = 0; i < 5; i++) begin
         access(ch[i], wr[i], 32'h0012_3450 + i * 4, 1'b0);
         chk(mem.chan_q, sel[i], "channels written");
         chk(mem.chk_q, cm[i], "check mode");
         chk(mem.wr_q, wr[i], "direction");
      end
   endtask : t_bcast
   initial begin
      repeat (2) @(posedge clock_i);
      srst_i <= 1'b0;
      t_reset_regs();
      t_init();
      t_refresh();
      t_map();
      t_bcast();
      close_out();
   end
endmodule : tb_sdram_addr_map_init_bcast
`default_nettype wire
